//--- rtl/adc_seq_pkg.sv
// constants shared by the sampling-control design files
// assumes a 40 MHz system clock and a 32-bit AHB-Lite register bus
package adc_seq_pkg;
  // system clock period
  localparam int CLK_PERIOD_NS = 25;
  // delay from convert-start fall to busy, longest times
  localparam int T_START_TO_BUSY_BYP_NS = 30;
  localparam int T_START_TO_BUSY_AMP_NS = 100;
  // conversion time, longest times
  localparam int T_CONVERSION_BYP_NS = 660;
  localparam int T_CONVERSION_AMP_NS = 1550;
  // longest times round down, but never below one cycle
  localparam int BUSY_BYP_CYC = (T_START_TO_BUSY_BYP_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (T_START_TO_BUSY_BYP_NS / CLK_PERIOD_NS);
  localparam int BUSY_AMP_CYC = (T_START_TO_BUSY_AMP_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (T_START_TO_BUSY_AMP_NS / CLK_PERIOD_NS);
  localparam int CONV_BYP_CYC = (T_CONVERSION_BYP_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (T_CONVERSION_BYP_NS / CLK_PERIOD_NS);
  localparam int CONV_AMP_CYC = (T_CONVERSION_AMP_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (T_CONVERSION_AMP_NS / CLK_PERIOD_NS);
  localparam int CNT_W = 7;

  // result word and tag layout
  localparam int CODE_W = 14;
  localparam int RAW_W = 16;
  localparam int SEL_W = 3;
  localparam int WORD_W = CODE_W + 2 * SEL_W;
  localparam logic signed [RAW_W-1:0] CODE_MAX = 16'sh1fff;
  localparam logic signed [RAW_W-1:0] CODE_MIN = -16'sh2000;
  localparam logic [SEL_W-1:0] LAST_PAIR = 3'h7;

  // register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam int CFG_SOFT_OFF_BIT = 0;

  // conversion sequencing, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LAUNCH = 3'b010,
    ST_CONVERT = 3'b100
  } conv_state_e;

  // amplifier gain for a select code, ascending
  function automatic logic [4:0] gain_of(input logic [SEL_W-1:0] code);
    logic [4:0] g;
    g = 5'h01;
    case (code)
      3'h0: g = 5'h01;
      3'h1: g = 5'h02;
      3'h2: g = 5'h03;
      3'h3: g = 5'h04;
      3'h4: g = 5'h06;
      3'h5: g = 5'h08;
      3'h6: g = 5'h0c;
      default: g = 5'h10;
    endcase
    return g;
  endfunction : gain_of

  // saturate a raw core result to the output code range
  function automatic logic [CODE_W-1:0] clamp_code(input logic signed [RAW_W-1:0] raw);
    logic signed [RAW_W-1:0] v;
    v = raw;
    if (raw > CODE_MAX)
    begin
      v = CODE_MAX;
    end
    else if (raw < CODE_MIN)
    begin
      v = CODE_MIN;
    end
    return v[CODE_W-1:0];
  endfunction : clamp_code
endpackage : adc_seq_pkg

//--- rtl/shift_if.sv
// handshake between the sequencing core and the serial shifter
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface shift_if;
  import adc_seq_pkg::*;
  logic load;
  logic [WORD_W-1:0] word;
  logic shift;
  logic clear;
  logic ser_out;
  modport ctrl (output load, output word, output shift, output clear, input ser_out);
  modport shifter (input load, input word, input shift, input clear, output ser_out);
endinterface : shift_if

//--- rtl/result_shifter.sv
// serial shifter for the result word and its tag bits
// assumes strobes are single-cycle and synchronous to CLOCK
`timescale 1ns/1ps
module result_shifter
  import adc_seq_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  shift_if.shifter sh
);
  logic [WORD_W-1:0] shreg_r;

  // code msb first, then channel then gain tags, msb first
  always_ff @(posedge clock)
  begin
    if (reset || sh.clear)
    begin
      shreg_r <= '0;
    end
    else if (sh.load)
    begin
      shreg_r <= sh.word;
    end
    else if (sh.shift)
    begin
      shreg_r <= {shreg_r[WORD_W-2:0], 1'b0};
    end
  end

  // top bit is always what stands on the pin
  assign sh.ser_out = shreg_r[WORD_W-1];
endmodule : result_shifter

//--- rtl/adc_seq_ctrl.sv
// sampling-control logic of an eight-input serial converter
// assumes host pins are asynchronous; RAW_CODE comes from the core on CLOCK
// Functional notes
// - low-power acquisition lasts whole start-high time
// - bypassed, busy rises 30ns after start fall; code raises it 100-125ns after the pin falls
// - bypassed, conversion ends within 660ns
// - amplified, conversion 1550ns, busy within 100ns; code raises busy 175-200ns after the pin falls
// - six extra clocks shift out tag bits
// - tags: channel msb first, then gain
// - channel and gain latched on start rise
// - normal mode applies selections one sample later
// - low-power mode applies selections same sample
// - one shared amplifier, bypass or eight gains
// - output codes saturate to fourteen-bit range
// - scan cycles pairs 0..7 on start rise
// - normal scan: first sample init, second discarded
// - channel selects ignored while scanning
// - gain selects stay live during scan
// - scan tags report sequencer pair
// - one more sequenced pair after scan ends
// - low-power first sample after wake valid
// - start fall samples and starts conversion
// - busy high throughout conversion
// - busy fall shows bit 13, clocks shift
`timescale 1ns/1ps
module adc_seq_ctrl
  import adc_seq_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic CONV_START,
  input wire logic SERIAL_CLK,
  input wire logic [SEL_W-1:0] CHAN_SEL,
  input wire logic [SEL_W-1:0] GAIN_SEL,
  input wire logic LOW_POWER_SEL,
  input wire logic GAIN_AMP_BYPASS,
  input wire logic SCAN,
  input wire logic POWER_DOWN_N,
  input wire logic [RAW_W-1:0] RAW_CODE,
  output logic SERIAL_RESULT_OUT,
  output logic SERIAL_RESULT_OE,
  output logic BUSY,
  output logic TRACK,
  output logic [SEL_W-1:0] MUX_CHAN,
  output logic [4:0] AMP_GAIN,
  output logic AMP_BYPASS,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP
);
  localparam int NSYNC = 2 + 2 * SEL_W + 4;

  // two-stage synchronisers, plus a third stage for edges
  logic [NSYNC-1:0] s1_r;
  logic [NSYNC-1:0] s2_r;
  logic cs_d_r;
  logic sclk_d_r;
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      s1_r <= '0;
      s2_r <= '0;
      cs_d_r <= 1'b0;
      sclk_d_r <= 1'b0;
    end
    else
    begin
      s1_r <= {CONV_START, SERIAL_CLK, CHAN_SEL, GAIN_SEL, LOW_POWER_SEL,
               GAIN_AMP_BYPASS, SCAN, POWER_DOWN_N};
      s2_r <= s1_r;
      cs_d_r <= s2_r[NSYNC-1];
      sclk_d_r <= s2_r[NSYNC-2];
    end
  end

  logic cs_s, sclk_s, lp_s, byp_s, scan_s, pdn_s;
  logic [SEL_W-1:0] chan_s, gain_s;
  assign {cs_s, sclk_s, chan_s, gain_s, lp_s, byp_s, scan_s, pdn_s} = s2_r;
  logic cs_rise, cs_fall, sclk_rise;
  assign cs_rise = cs_s && !cs_d_r;
  assign cs_fall = !cs_s && cs_d_r;
  assign sclk_rise = sclk_s && !sclk_d_r;

  logic soft_off_r;
  logic powered;
  assign powered = pdn_s && !soft_off_r;

  // selection capture and scan sequencer, all on start rise
  logic [SEL_W-1:0] chan_cap_r, gain_cap_r, chan_prev_r, gain_prev_r;
  logic [SEL_W-1:0] seq_pos_r;
  logic scan_run_r, seq_use_r, discard_r, scan_init_r;
  always_ff @(posedge CLOCK)
  begin
    if (RESET || !powered)
    begin
      chan_cap_r <= '0;
      gain_cap_r <= '0;
      chan_prev_r <= '0;
      gain_prev_r <= '0;
      seq_pos_r <= LAST_PAIR;
      scan_run_r <= 1'b0;
      seq_use_r <= 1'b0;
      discard_r <= 1'b0;
      scan_init_r <= 1'b0;
    end
    else if (cs_rise)
    begin
      chan_cap_r <= chan_s;
      gain_cap_r <= gain_s;
      chan_prev_r <= chan_cap_r;
      gain_prev_r <= gain_cap_r;
      discard_r <= scan_init_r && !lp_s;
      scan_init_r <= 1'b0;
      if (scan_s && !scan_run_r)
      begin
        // first scan edge only primes the sequencer
        scan_run_r <= 1'b1;
        scan_init_r <= 1'b1;
        seq_pos_r <= LAST_PAIR;
        seq_use_r <= 1'b0;
        discard_r <= 1'b1;
      end
      else if (scan_run_r)
      begin
        seq_pos_r <= seq_pos_r + 3'h1;
        seq_use_r <= 1'b1;
        scan_run_r <= scan_s;
      end
      else
      begin
        seq_use_r <= 1'b0;
      end
    end
  end

  // selections that the next conversion would use
  logic [SEL_W-1:0] chan_pend, gain_pend;
  always_comb
  begin
    gain_pend = lp_s ? gain_cap_r : gain_prev_r;
    if (seq_use_r)
    begin
      chan_pend = seq_pos_r;
    end
    else
    begin
      chan_pend = lp_s ? chan_cap_r : chan_prev_r;
    end
  end

  // conversion sequencing
  conv_state_e state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [SEL_W-1:0] chan_app_r, gain_app_r;
  logic byp_app_r;
  logic first_pend_r, sample_ok_r;
  logic [CODE_W-1:0] result_r;
  logic [15:0] count_r;
  always_ff @(posedge CLOCK)
  begin
    if (RESET || !powered)
    begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      chan_app_r <= '0;
      gain_app_r <= '0;
      byp_app_r <= 1'b1;
      first_pend_r <= 1'b1;
      sample_ok_r <= 1'b0;
      result_r <= '0;
      count_r <= '0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (cs_fall)
          begin
            state_r <= ST_LAUNCH;
            chan_app_r <= chan_pend;
            gain_app_r <= gain_pend;
            byp_app_r <= byp_s;
            // normal mode wakes on the first pulse, so that sample is bad
            sample_ok_r <= (lp_s || !first_pend_r) && !discard_r;
            first_pend_r <= 1'b0;
            cnt_r <= byp_s ? CNT_W'(BUSY_BYP_CYC - 1) : CNT_W'(BUSY_AMP_CYC - 1);
          end
        end
        ST_LAUNCH:
        begin
          if (cnt_r == '0)
          begin
            state_r <= ST_CONVERT;
            cnt_r <= byp_app_r ? CNT_W'(CONV_BYP_CYC - 1) : CNT_W'(CONV_AMP_CYC - 1);
          end
          else
          begin
            cnt_r <= cnt_r - CNT_W'(1);
          end
        end
        ST_CONVERT:
        begin
          if (cnt_r == '0)
          begin
            state_r <= ST_IDLE;
            result_r <= clamp_code(RAW_CODE);
            count_r <= count_r + 16'h0001;
          end
          else
          begin
            cnt_r <= cnt_r - CNT_W'(1);
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  logic conv_done;
  assign conv_done = (state_r == ST_CONVERT) && (cnt_r == '0);

  // busy and tracking outputs from flops
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      BUSY <= 1'b0;
      TRACK <= 1'b0;
      SERIAL_RESULT_OE <= 1'b0;
    end
    else
    begin
      BUSY <= (state_r == ST_CONVERT) && !conv_done && powered;
      // low-power acquisition spans the whole start-high level
      TRACK <= powered && (lp_s ? cs_s : (state_r == ST_IDLE));
      SERIAL_RESULT_OE <= powered && !cs_s;
    end
  end

  // applied selections seen by the analog path
  assign MUX_CHAN = chan_app_r;
  assign AMP_GAIN = gain_of(gain_app_r);
  assign AMP_BYPASS = byp_app_r;

  shift_if sh ();
  assign sh.clear = cs_fall || !powered;
  assign sh.load = conv_done;
  assign sh.word = {clamp_code(RAW_CODE), chan_app_r, gain_app_r};
  assign sh.shift = sclk_rise && (state_r == ST_IDLE) && !cs_s;
  assign SERIAL_RESULT_OUT = sh.ser_out;

  result_shifter u_shifter (
    .clock(CLOCK),
    .reset(RESET),
    .sh(sh)
  );

  // ahb-lite slave, zero wait states, always okay
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] rdata_r;
  logic take;
  assign take = HSEL && HTRANS[1] && HREADY;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_r;

  // read word for an address, unmapped reads as zero
  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (a == OFS_CONFIG)
    begin
      w = {31'h0, soft_off_r};
    end
    else if (a == OFS_STATUS)
    begin
      w = {18'h0, scan_run_r, seq_pos_r, sample_ok_r, byp_app_r, gain_app_r,
           chan_app_r, lp_s, BUSY};
    end
    else if (a == OFS_RESULT)
    begin
      w = {18'h0, result_r};
    end
    else if (a == OFS_COUNT)
    begin
      w = {16'h0, count_r};
    end
    return w;
  endfunction : read_word

  // address phase registered, read data prepared for the data phase
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      rdata_r <= '0;
    end
    else
    begin
      wr_pend_r <= take && HWRITE;
      wr_addr_r <= HADDR[7:0];
      rdata_r <= (take && !HWRITE) ? read_word(HADDR[7:0]) : 32'h0000_0000;
    end
  end

  // config register: software power-down halts conversions
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      soft_off_r <= CONFIG_RESET[CFG_SOFT_OFF_BIT];
    end
    else if (wr_pend_r && wr_addr_r == OFS_CONFIG)
    begin
      soft_off_r <= HWDATA[CFG_SOFT_OFF_BIT];
    end
  end
endmodule : adc_seq_ctrl

//--- dv/adc_seq_ctrl_sva.sv
// checker for the sampling-control pins of adc_seq_ctrl
// assumes single clock domain; bound below, sees top ports only
`timescale 1ns/1ps
module adc_seq_ctrl_sva
  import adc_seq_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic CONV_START,
  input wire logic GAIN_AMP_BYPASS,
  input wire logic LOW_POWER_SEL,
  input wire logic SCAN,
  input wire logic POWER_DOWN_N,
  input wire logic [RAW_W-1:0] RAW_CODE,
  input wire logic SERIAL_RESULT_OUT,
  input wire logic SERIAL_RESULT_OE,
  input wire logic BUSY,
  input wire logic TRACK,
  input wire logic [SEL_W-1:0] MUX_CHAN,
  input wire logic [4:0] AMP_GAIN,
  input wire logic AMP_BYPASS
);
  logic [6:0] busy_cnt_r;
  // busy run length, saturating so a stuck busy never wraps to a pass
  always_ff @(posedge CLOCK)
  begin
    if (RESET || !BUSY)
      busy_cnt_r <= 7'h00;
    else if (busy_cnt_r != 7'h7f)
      busy_cnt_r <= busy_cnt_r + 7'h01;
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  a_busy_rise_byp: assert property (
    $fell(CONV_START) && !BUSY && POWER_DOWN_N && GAIN_AMP_BYPASS |-> ##[1:7] BUSY)
    else $error("busy late after bypassed start");
  a_busy_rise_amp: assert property (
    $fell(CONV_START) && !BUSY && POWER_DOWN_N && !GAIN_AMP_BYPASS |-> ##[1:10] BUSY)
    else $error("busy late after amplified start");
  a_conv_len_byp: assert property (BUSY && AMP_BYPASS |-> busy_cnt_r < 7'h1a)
    else $error("bypassed conversion too long");
  a_conv_len_amp: assert property (BUSY && !AMP_BYPASS |-> busy_cnt_r < 7'h3e)
    else $error("amplified conversion too long");
  a_busy_whole: assert property ($fell(BUSY) |-> busy_cnt_r >= 7'h14)
    else $error("busy dropped early");
  a_msb_first: assert property (
    $fell(BUSY) |-> SERIAL_RESULT_OE && SERIAL_RESULT_OUT == $past(RAW_CODE[RAW_W-1]))
    else $error("top result bit not shown at busy fall");
  a_sel_held: assert property (
    BUSY && $past(BUSY) |-> $stable(MUX_CHAN) && $stable(AMP_GAIN))
    else $error("selection moved during conversion");
  a_gain_set: assert property (
    AMP_GAIN inside {5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10})
    else $error("gain outside the offered set");
  a_scan_step: assert property (
    SCAN && $past(SCAN) && $changed(MUX_CHAN) |->
      MUX_CHAN == $past(MUX_CHAN) + 3'h1 || MUX_CHAN == 3'h0)
    else $error("sequencer skipped a pair");
  a_lp_track: assert property (
    (LOW_POWER_SEL && CONV_START && POWER_DOWN_N) [*5] |-> TRACK)
    else $error("no acquisition while start high");
endmodule : adc_seq_ctrl_sva
bind adc_seq_ctrl adc_seq_ctrl_sva chk (.*);

//--- dv/host_model.sv
// host controller model: start pulse, selects, serial clock, word readout
// assumes the device answers on busy and shifts on detected clock rises
`timescale 1ns/1ps
module host_model
  import adc_seq_pkg::*;
(
  input wire logic CLOCK,
  input wire logic BUSY,
  input wire logic SERIAL_RESULT_OUT,
  output logic CONV_START,
  output logic SERIAL_CLK,
  output logic [SEL_W-1:0] CHAN_SEL,
  output logic [SEL_W-1:0] GAIN_SEL
);
  // start and serial clock idle low between frames
  initial
  begin
    CONV_START = 1'b0;
    SERIAL_CLK = 1'b0;
    CHAN_SEL = 3'h0;
    GAIN_SEL = 3'h0;
  end
  // one sample; word stays unknown if busy never comes
  task automatic sample(input logic [SEL_W-1:0] ch, input logic [SEL_W-1:0] g,
    output logic [WORD_W-1:0] word);
    int n;
    word = 'x;
    @(posedge CLOCK);
    CHAN_SEL <= ch;
    GAIN_SEL <= g;
    repeat (4) @(posedge CLOCK);
    CONV_START <= 1'b1;
    // 20 cycles is 500 ns, enough for either mode
    repeat (20) @(posedge CLOCK);
    CONV_START <= 1'b0;
    for (n = 0; n < 20 && BUSY !== 1'b1; n++) @(posedge CLOCK);
    if (BUSY !== 1'b1)
      return;
    for (n = 0; n < 100 && BUSY !== 1'b0; n++) @(posedge CLOCK);
    word[WORD_W-1] = SERIAL_RESULT_OUT;
    // 200 ns clock, read just before each next rise
    for (n = 1; n < WORD_W; n++)
    begin
      SERIAL_CLK <= 1'b1;
      repeat (4) @(posedge CLOCK);
      SERIAL_CLK <= 1'b0;
      repeat (4) @(posedge CLOCK);
      word[WORD_W-1-n] = SERIAL_RESULT_OUT;
    end
  endtask : sample
endmodule : host_model

//--- dv/tb_top.sv
// testbench for adc_seq_ctrl: host model on the pins, bench as bus master
// assumes 40 MHz clock and a single AHB-Lite slave
`timescale 1ns/1ps
module tb_top;
  import adc_seq_pkg::*;
  logic clock, reset, conv_start, serial_clk, low_power, bypass, scan, power_down_n;
  logic ser_out, ser_oe, busy, track, amp_bypass, hsel, hwrite, hreadyout, hresp;
  logic [SEL_W-1:0] chan_sel, gain_sel, mux_chan;
  logic [RAW_W-1:0] raw_code;
  logic [4:0] amp_gain;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [WORD_W-1:0] word;
  int miscompares, cmp_count;
  logic [4:0] gains [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10};
  logic [15:0] raws [8] = '{16'h7fff, 16'h8000, 16'h1fff, 16'h2000, 16'hdfff, 16'he000,
    16'h0123, 16'hffff};

  adc_seq_ctrl dut (.CLOCK(clock), .RESET(reset), .CONV_START(conv_start),
    .SERIAL_CLK(serial_clk), .CHAN_SEL(chan_sel), .GAIN_SEL(gain_sel),
    .LOW_POWER_SEL(low_power), .GAIN_AMP_BYPASS(bypass), .SCAN(scan),
    .POWER_DOWN_N(power_down_n), .RAW_CODE(raw_code), .SERIAL_RESULT_OUT(ser_out),
    .SERIAL_RESULT_OE(ser_oe), .BUSY(busy), .TRACK(track), .MUX_CHAN(mux_chan),
    .AMP_GAIN(amp_gain), .AMP_BYPASS(amp_bypass), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp));
  host_model host (.CLOCK(clock), .BUSY(busy), .SERIAL_RESULT_OUT(ser_out),
    .CONV_START(conv_start),
    .SERIAL_CLK(serial_clk), .CHAN_SEL(chan_sel), .GAIN_SEL(gain_sel));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // single word transfer; wait states honoured, entered just after an edge
  task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= addr;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
    check(32'(hresp), 32'h0);
  endtask : ahb

  // own saturation, independent of the design's helper
  function automatic logic [CODE_W-1:0] sat14(input logic signed [RAW_W-1:0] r);
    if (r > 16'sh1fff)
      return 14'h1fff;
    if (r < -16'sh2000)
      return 14'h2000;
    return r[CODE_W-1:0];
  endfunction : sat14

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // 25 samples of under 300 cycles each, with ample margin
  initial
  begin
    #2000000;
    miscompares++;
    conclude();
  end

  initial
  begin
    reset = 1'b1;
    low_power = 1'b1;
    bypass = 1'b0;
    scan = 1'b0;
    power_down_n = 1'b1;
    raw_code = 16'h0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    repeat (4) @(posedge clock);
    // low power, amplified: every gain code and clamp boundary
    for (int i = 0; i < 8; i++)
    begin
      raw_code <= raws[i];
      host.sample(3'(i), 3'(i), word);
      check(32'(word), 32'({sat14(raws[i]), 3'(i), 3'(i)}));
      check(32'(amp_gain), 32'(gains[i]));
    end
    $display("test low power gains done");
    // normal mode, bypassed: selections land one sample late
    low_power <= 1'b0;
    bypass <= 1'b1;
    host.sample(3'h5, 3'h3, word);
    host.sample(3'h2, 3'h6, word);
    check(32'(word[5:0]), 32'h2b);
    host.sample(3'h2, 3'h6, word);
    check(32'(word[5:0]), 32'h16);
    check(32'(amp_bypass), 32'h1);
    $display("test normal delay done");
    // low power scan: priming sample dropped, wrap, one extra pair
    low_power <= 1'b1;
    scan <= 1'b1;
    host.sample(3'h2, 3'h4, word);
    // priming sample flagged invalid, pair zero valid in low power
    ahb(1'b0, 32'(OFS_STATUS), 32'h0);
    check(32'(rd[9]), 32'h0);
    for (int i = 0; i < 9; i++)
    begin
      host.sample(3'h2, 3'h4, word);
      check(32'(word[5:0]), 32'({3'(i), 3'h4}));
      if (i == 0)
      begin
        ahb(1'b0, 32'(OFS_STATUS), 32'h0);
        check(32'(rd[9]), 32'h1);
      end
    end
    scan <= 1'b0;
    host.sample(3'h3, 3'h4, word);
    check(32'(word[5:3]), 32'h1);
    host.sample(3'h3, 3'h4, word);
    check(32'(word[5:3]), 32'h3);
    $display("test scan done");
    // registers: result, config reset and write, unmapped place
    ahb(1'b0, 32'(OFS_RESULT), 32'h0);
    check(rd, 32'(sat14(raw_code)));
    // 23 conversions so far; status of the last low-power sample
    ahb(1'b0, 32'(OFS_COUNT), 32'h0);
    check(rd, 32'h17);
    ahb(1'b0, 32'(OFS_STATUS), 32'h0);
    check(rd, 32'h78e);
    ahb(1'b0, 32'(OFS_CONFIG), 32'h0);
    check(rd, CONFIG_RESET);
    ahb(1'b1, 32'(OFS_CONFIG), 32'h1);
    ahb(1'b0, 32'(OFS_CONFIG), 32'h0);
    check(rd, 32'h1);
    ahb(1'b1, 32'(OFS_CONFIG), 32'h0);
    ahb(1'b1, 32'h10, 32'hffff_ffff);
    ahb(1'b0, 32'h10, 32'h0);
    check(rd, 32'h0);
    $display("test registers done");
    // after a wake the low-power sample is good, the normal one is not
    host.sample(3'h1, 3'h2, word);
    check(32'(word[5:0]), 32'h0a);
    ahb(1'b0, 32'(OFS_STATUS), 32'h0);
    check(32'(rd[9]), 32'h1);
    power_down_n <= 1'b0;
    repeat (4) @(posedge clock);
    power_down_n <= 1'b1;
    low_power <= 1'b0;
    host.sample(3'h1, 3'h2, word);
    ahb(1'b0, 32'(OFS_STATUS), 32'h0);
    check(32'(rd[9]), 32'h0);
    $display("test wake done");
    conclude();
  end
endmodule : tb_top
